// ---- verilog/pled_pkg.sv ----
// Purpose: Shared constants and types for the PHY indicator driver
// Assumes: 125 MHz core clock
// Notes:   Pin level high means the indicator is off
package pled_pkg;

   localparam int unsigned CLK_HZ = 125_000_000;

   // Blink frequencies in centihertz, index by rate field
   localparam int unsigned BLINK_CHZ_0 = 250;
   localparam int unsigned BLINK_CHZ_1 = 500;
   localparam int unsigned BLINK_CHZ_2 = 1000;
   localparam int unsigned BLINK_CHZ_3 = 2000;
   // Half blink period in cycles
   localparam int unsigned BLINK_HALF_0 = (CLK_HZ / BLINK_CHZ_0) * 50;
   localparam int unsigned BLINK_HALF_1 = (CLK_HZ / BLINK_CHZ_1) * 50;
   localparam int unsigned BLINK_HALF_2 = (CLK_HZ / BLINK_CHZ_2) * 50;
   localparam int unsigned BLINK_HALF_3 = (CLK_HZ / BLINK_CHZ_3) * 50;

   // Pulse-stretch lengths in ms
   localparam int unsigned STRETCH_MS_0 = 50;
   localparam int unsigned STRETCH_MS_1 = 100;
   localparam int unsigned STRETCH_MS_2 = 200;
   localparam int unsigned STRETCH_MS_3 = 400;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   // Half pulse period in cycles
   localparam int unsigned STRETCH_HALF_0 = STRETCH_MS_0 * CYC_PER_MS / 2;
   localparam int unsigned STRETCH_HALF_1 = STRETCH_MS_1 * CYC_PER_MS / 2;
   localparam int unsigned STRETCH_HALF_2 = STRETCH_MS_2 * CYC_PER_MS / 2;
   localparam int unsigned STRETCH_HALF_3 = STRETCH_MS_3 * CYC_PER_MS / 2;

   // Pulsing: 5 kHz, 20 percent on
   localparam int unsigned PULSE_HZ     = 5000;
   localparam int unsigned PULSE_DUTY   = 20;
   localparam int unsigned PULSE_PERIOD = CLK_HZ / PULSE_HZ;
   localparam int unsigned PULSE_ON     = PULSE_PERIOD * PULSE_DUTY / 100;

   localparam int unsigned TW = 26;
   localparam int unsigned PW = 15;

   localparam logic [TW-1:0] TMR_RST = 26'h0000000;
   localparam logic [PW-1:0] PWM_RST = 15'h0000;

   // Function codes
   localparam logic [3:0] FN_LINK_ANY  = 4'h0;
   localparam logic [3:0] FN_LINK_1000 = 4'h1;
   localparam logic [3:0] FN_LINK_100  = 4'h2;
   localparam logic [3:0] FN_LINK_10   = 4'h3;
   localparam logic [3:0] FN_LINK_HI   = 4'h4;
   localparam logic [3:0] FN_LINK_10G  = 4'h5;
   localparam logic [3:0] FN_LINK_LO   = 4'h6;
   localparam logic [3:0] FN_DUPLEX    = 4'h8;
   localparam logic [3:0] FN_COLL      = 4'h9;
   localparam logic [3:0] FN_ACT       = 4'ha;
   localparam logic [3:0] FN_ANFAULT   = 4'hc;
   localparam logic [3:0] FN_OFF       = 4'he;
   localparam logic [3:0] FN_ON        = 4'hf;

   typedef enum logic [1:0] {
      PLED_SPD_10,
      PLED_SPD_100,
      PLED_SPD_1000,
      PLED_SPD_RSVD
   } pled_speed_t;

   typedef enum logic [1:0] {
      PLED_M_INDIV,
      PLED_M_TRI,
      PLED_M_ENH
   } pled_mode_t;

   // Status from the link, activity and control logic
   typedef struct packed {
      logic        link_up;
      pled_speed_t speed;
      logic        full_duplex;
      logic        rx_act;
      logic        tx_act;
      logic        collision;
      logic        an_fault;
   } pled_status_t;

   // Per-pin enhanced configuration
   typedef struct packed {
      logic [3:0] func;
      logic       combine_dis;
      logic       stretch_en;
      logic [1:0] rate;
   } pled_pin_cfg_t;

   typedef enum logic [1:0] {
      PLED_E_IDLE,
      PLED_E_BLINK,
      PLED_E_HOLD,
      PLED_E_REST
   } pled_ev_st_t;

endpackage

// ---- verilog/pled_event_timer.sv ----
// Purpose: Blink or pulse-stretch shaping of one indicator event
// Assumes: ev is a level from same-clock logic
// Notes:   One instance per pin, so timing is independent per pin
`timescale 1ns/100ps
module pled_event_timer (
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              ev,
   input  wire logic              stretch_en,
   input  wire logic [1:0]        rate,
   output logic                   shown
);

   typedef struct packed {
      pled_pkg::pled_ev_st_t    st;
      logic [pled_pkg::TW-1:0] cnt;
      logic                    seen;
      logic                    shown;
   } pled_et_state_t;

   pled_et_state_t s_q;
   pled_et_state_t s_d;

   function automatic logic [pled_pkg::TW-1:0] half_len(
      input logic       str,
      input logic [1:0] r
   );
      logic [pled_pkg::TW-1:0] v;
      v = pled_pkg::TW'(pled_pkg::BLINK_HALF_0);
      case ({str, r})
         3'h0: v = pled_pkg::TW'(pled_pkg::BLINK_HALF_0);
         3'h1: v = pled_pkg::TW'(pled_pkg::BLINK_HALF_1);
         3'h2: v = pled_pkg::TW'(pled_pkg::BLINK_HALF_2);
         3'h3: v = pled_pkg::TW'(pled_pkg::BLINK_HALF_3);
         3'h4: v = pled_pkg::TW'(pled_pkg::STRETCH_HALF_0);
         3'h5: v = pled_pkg::TW'(pled_pkg::STRETCH_HALF_1);
         3'h6: v = pled_pkg::TW'(pled_pkg::STRETCH_HALF_2);
         default: v = pled_pkg::TW'(pled_pkg::STRETCH_HALF_3);
      endcase
      return v;
   endfunction

   logic [pled_pkg::TW-1:0] half;
   logic                    last;

   assign half = half_len(stretch_en, rate);
   assign last = (s_q.cnt >= half - pled_pkg::TW'(1));

   always_comb begin
      s_d = s_q;
      s_d.cnt = s_q.cnt + pled_pkg::TW'(1);
      s_d.seen = s_q.seen | ev;
      case (s_q.st)
         pled_pkg::PLED_E_IDLE: begin
            s_d.cnt = pled_pkg::TMR_RST;
            s_d.seen = 1'b0;
            s_d.shown = 1'b0;
            if (ev) begin
               s_d.shown = 1'b1;
               s_d.st = stretch_en ? pled_pkg::PLED_E_HOLD
                                   : pled_pkg::PLED_E_BLINK;
            end
         end
         // Half period changed, half period resting, repeat while busy
         pled_pkg::PLED_E_BLINK: begin
            if (last) begin
               s_d.cnt = pled_pkg::TMR_RST;
               s_d.shown = ~s_q.shown;
               if (!s_q.shown) begin
                  s_d.seen = 1'b0;
                  if (!(s_q.seen | ev)) begin
                     // Stay dark; idle would otherwise see one lit cycle
                     s_d.shown = 1'b0;
                     s_d.st = pled_pkg::PLED_E_IDLE;
                  end
               end
            end
         end
         // Held in half periods; at least two, more while events go on
         pled_pkg::PLED_E_HOLD: begin
            if (last) begin
               s_d.cnt = pled_pkg::TMR_RST;
               s_d.seen = 1'b0;
               if (!s_q.seen || !s_q.shown) begin
                  s_d.shown = 1'b1;
               end
               if (s_q.shown && !(s_q.seen | ev)) begin
                  s_d.shown = 1'b0;
                  s_d.st = pled_pkg::PLED_E_REST;
               end
            end
         end
         pled_pkg::PLED_E_REST: begin
            s_d.shown = 1'b0;
            if (last) begin
               s_d.st = pled_pkg::PLED_E_IDLE;
            end
         end
         default: s_d.st = pled_pkg::PLED_E_IDLE;
      endcase
      // First hold half period marks itself by setting seen
      if (s_q.st == pled_pkg::PLED_E_IDLE && ev && stretch_en) begin
         s_d.shown = 1'b1;
         s_d.seen = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '{st: pled_pkg::PLED_E_IDLE, cnt: pled_pkg::TMR_RST,
                  seen: 1'b0, shown: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign shown = s_q.shown;

endmodule

// ---- verilog/pled_top.sv ----
// Purpose: Drives the two indicator pins from PHY status
// Assumes: Status and control from same-clock logic; strap is a pin
// Notes:   Pin low is indicator on; mode settles on the third clock after reset release
`timescale 1ns/100ps
module pled_top (
   input  wire logic                     clk,
   input  wire logic                     resetn,
   input  wire logic                     style_strap,
   input  wire logic                     legacy_indicator_select,
   input  wire logic                     isolate_control,
   input  wire logic                     power_down,
   input  wire logic                     pulsing_en,
   input  wire logic                     act_tx_only,
   input  wire pled_pkg::pled_status_t   status,
   input  wire pled_pkg::pled_pin_cfg_t  cfg_first,
   input  wire pled_pkg::pled_pin_cfg_t  cfg_second,
   output logic                          first_indicator_pin,
   output logic                          second_indicator_pin,
   output logic                          indiv_mode,
   output logic                          enhanced_mode
);

   typedef struct packed {
      logic [1:0]              strap_sync;
      logic [1:0]              strap_wait;
      logic                    strap_taken;
      logic                    strap_val;
      logic [pled_pkg::TW-1:0] tog_cnt;
      logic                    tog;
      logic [pled_pkg::PW-1:0] pwm_cnt;
      logic                    first_pin;
      logic                    second_pin;
   } pled_top_state_t;

   pled_top_state_t s_q;
   pled_top_state_t s_d;

   // Primary condition of a function code (asserted = on)
   function automatic logic primary_on(
      input logic [3:0]             fn,
      input pled_pkg::pled_status_t st
   );
      logic g;
      logic h;
      logic t;
      logic r;
      g = st.link_up && st.speed == pled_pkg::PLED_SPD_1000;
      h = st.link_up && st.speed == pled_pkg::PLED_SPD_100;
      t = st.link_up && st.speed == pled_pkg::PLED_SPD_10;
      r = 1'b0;
      case (fn)
         pled_pkg::FN_LINK_ANY:  r = st.link_up;
         pled_pkg::FN_LINK_1000: r = g;
         pled_pkg::FN_LINK_100:  r = h;
         pled_pkg::FN_LINK_10:   r = t;
         pled_pkg::FN_LINK_HI:   r = h | g;
         pled_pkg::FN_LINK_10G:  r = t | g;
         pled_pkg::FN_LINK_LO:   r = t | h;
         pled_pkg::FN_DUPLEX:    r = st.link_up && st.full_duplex;
         pled_pkg::FN_ANFAULT:   r = st.an_fault;
         pled_pkg::FN_ON:        r = 1'b1;
         default:                r = 1'b0;
      endcase
      return r;
   endfunction

   // Secondary event of a function code
   function automatic logic event_of(
      input logic [3:0]             fn,
      input pled_pkg::pled_status_t st,
      input logic                   tx_only
   );
      logic act;
      logic e;
      act = tx_only ? st.tx_act : (st.tx_act | st.rx_act);
      e = 1'b0;
      case (fn)
         pled_pkg::FN_LINK_ANY, pled_pkg::FN_LINK_1000,
         pled_pkg::FN_LINK_100, pled_pkg::FN_LINK_10,
         pled_pkg::FN_LINK_HI, pled_pkg::FN_LINK_10G,
         pled_pkg::FN_LINK_LO:
            e = primary_on(fn, st) && (st.tx_act | st.rx_act);
         pled_pkg::FN_DUPLEX:
            e = st.link_up && !st.full_duplex && st.collision;
         pled_pkg::FN_COLL: e = st.collision;
         pled_pkg::FN_ACT:  e = act;
         default:           e = 1'b0;
      endcase
      return e;
   endfunction

   // Whether a shaped event turns the pin off (link codes) or on
   function automatic logic flash_turns_off(input logic [3:0] fn);
      return fn <= pled_pkg::FN_LINK_LO;
   endfunction

   // Legacy speed pin: steady on when idle, toggle phase when busy
   function automatic logic legacy_lit(
      input logic act,
      input logic tog
   );
      return ~act | tog;
   endfunction

   // Final enhanced on/off for one pin
   function automatic logic enh_on(
      input logic [3:0] fn,
      input logic       prim,
      input logic       flash,
      input logic       comb_dis
   );
      logic r;
      r = prim;
      if (!comb_dis) begin
         if (flash_turns_off(fn)) begin
            r = prim & ~flash;
         end else if (fn == pled_pkg::FN_DUPLEX ||
                      fn == pled_pkg::FN_COLL ||
                      fn == pled_pkg::FN_ACT) begin
            r = prim | flash;
         end
      end
      return r;
   endfunction

   pled_pkg::pled_mode_t mode;
   logic any_act;
   logic ev_first;
   logic ev_second;
   logic fl_first;
   logic fl_second;
   logic on_first;
   logic on_second;
   logic pwm_gate;
   logic [pled_pkg::TW-1:0] tog_half;

   assign tog_half = pled_pkg::TW'(pled_pkg::BLINK_HALF_1);
   assign any_act = status.tx_act | status.rx_act;

   // Mode follows the select bit live; only the strap is latched
   always_comb begin
      if (!legacy_indicator_select) begin
         mode = pled_pkg::PLED_M_ENH;
      end else if (s_q.strap_val) begin
         mode = pled_pkg::PLED_M_INDIV;
      end else begin
         mode = pled_pkg::PLED_M_TRI;
      end
   end

   assign ev_first  = event_of(cfg_first.func, status, act_tx_only);
   assign ev_second = event_of(cfg_second.func, status, act_tx_only);

   // One timer per pin keeps rates and phases apart
   pled_event_timer u_tmr_first (
      .clk        (clk),
      .resetn     (resetn),
      .ev         (ev_first),
      .stretch_en (cfg_first.stretch_en),
      .rate       (cfg_first.rate),
      .shown      (fl_first)
   );

   pled_event_timer u_tmr_second (
      .clk        (clk),
      .resetn     (resetn),
      .ev         (ev_second),
      .stretch_en (cfg_second.stretch_en),
      .rate       (cfg_second.rate),
      .shown      (fl_second)
   );

   // Gate open for the first fifth of every pulsing period
   assign pwm_gate = (s_q.pwm_cnt < pled_pkg::PW'(pled_pkg::PULSE_ON));

   always_comb begin
      s_d = s_q;
      s_d.strap_sync = {s_q.strap_sync[0], style_strap};
      s_d.strap_wait = {s_q.strap_wait[0], 1'b1};
      // Capture waits until the synchroniser holds the pin level;
      // taking it earlier would latch the reset value of the flops
      if (s_q.strap_wait[1] && !s_q.strap_taken) begin
         s_d.strap_taken = 1'b1;
         s_d.strap_val = s_q.strap_sync[1];
      end
      // Free-running legacy toggle and pulsing counters
      // One shared toggle keeps both legacy pins blinking in step
      if (s_q.tog_cnt >= tog_half - pled_pkg::TW'(1)) begin
         s_d.tog_cnt = pled_pkg::TMR_RST;
         s_d.tog = ~s_q.tog;
      end else begin
         s_d.tog_cnt = s_q.tog_cnt + pled_pkg::TW'(1);
      end
      if (s_q.pwm_cnt >=
          pled_pkg::PW'(pled_pkg::PULSE_PERIOD - 1)) begin
         s_d.pwm_cnt = pled_pkg::PWM_RST;
      end else begin
         s_d.pwm_cnt = s_q.pwm_cnt + pled_pkg::PW'(1);
      end

      on_first  = 1'b0;
      on_second = 1'b0;
      case (mode)
         pled_pkg::PLED_M_INDIV: begin
            on_second = status.link_up;
            on_first  = any_act & s_q.tog;
         end
         pled_pkg::PLED_M_TRI: begin
            if (status.link_up) begin
               // Toggle phase high half drives on while active
               case (status.speed)
                  pled_pkg::PLED_SPD_1000:
                     on_second = legacy_lit(any_act, s_q.tog);
                  pled_pkg::PLED_SPD_100:
                     on_first = legacy_lit(any_act, s_q.tog);
                  pled_pkg::PLED_SPD_10: begin
                     on_first  = legacy_lit(any_act, s_q.tog);
                     on_second = legacy_lit(any_act, s_q.tog);
                  end
                  default: begin
                     on_first  = 1'b0;
                     on_second = 1'b0;
                  end
               endcase
            end
         end
         pled_pkg::PLED_M_ENH: begin
            on_first = enh_on(cfg_first.func,
                              primary_on(cfg_first.func, status),
                              fl_first, cfg_first.combine_dis);
            on_second = enh_on(cfg_second.func,
                               primary_on(cfg_second.func, status),
                               fl_second, cfg_second.combine_dis);
         end
         default: begin
            on_first  = 1'b0;
            on_second = 1'b0;
         end
      endcase

      // Isolate leaves enhanced mode alone; power-down does not
      if (mode != pled_pkg::PLED_M_ENH && isolate_control) begin
         on_first  = 1'b0;
         on_second = 1'b0;
      end
      if (power_down) begin
         on_first  = 1'b0;
         on_second = 1'b0;
      end
      // Pulsing cuts LED current to a fifth of the on time
      if (pulsing_en && !pwm_gate) begin
         on_first  = 1'b0;
         on_second = 1'b0;
      end
      s_d.first_pin  = ~on_first;
      s_d.second_pin = ~on_second;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '{strap_sync: 2'h0, strap_wait: 2'h0, strap_taken: 1'b0,
                  strap_val: 1'b0, tog_cnt: pled_pkg::TMR_RST, tog: 1'b0,
                  pwm_cnt: pled_pkg::PWM_RST,
                  first_pin: 1'b1, second_pin: 1'b1};
      end else begin
         s_q <= s_d;
      end
   end

   // Mode flags are combinational so they track the select bit at once
   assign first_indicator_pin  = s_q.first_pin;
   assign second_indicator_pin = s_q.second_pin;
   assign indiv_mode           = (mode == pled_pkg::PLED_M_INDIV);
   assign enhanced_mode        = (mode == pled_pkg::PLED_M_ENH);

endmodule

// ---- tb/pled_props.sv ----
// Purpose: Port-level checks for the indicator driver
// Assumes: Bound to pled_top; one clock domain
// Notes:   Flash timing is far too long to watch; levels only
`timescale 1ns/100ps
module pled_props (
   input wire logic                    clk,
   input wire logic                    resetn,
   input wire logic                    style_strap,
   input wire logic                    legacy_indicator_select,
   input wire logic                    isolate_control,
   input wire logic                    power_down,
   input wire logic                    pulsing_en,
   input wire logic                    act_tx_only,
   input wire pled_pkg::pled_status_t  status,
   input wire pled_pkg::pled_pin_cfg_t cfg_first,
   input wire pled_pkg::pled_pin_cfg_t cfg_second,
   input wire logic                    first_indicator_pin,
   input wire logic                    second_indicator_pin,
   input wire logic                    indiv_mode,
   input wire logic                    enhanced_mode
);
   logic [2:0] age_q;
   logic [2:0] age_d;
   logic       enh_ok;
   logic       leg_ok;

   // Strap capture is over well before the count saturates
   assign age_d  = (age_q == 3'h7) ? age_q : age_q + 3'h1;
   assign enh_ok = enhanced_mode && !power_down && !pulsing_en;
   assign leg_ok = !enhanced_mode && !isolate_control && !power_down &&
                   !pulsing_en;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         age_q <= 3'h0;
      else
         age_q <= age_d;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   a_pd_forces_off: assert property (power_down [*2] |->
      first_indicator_pin && second_indicator_pin)
      else $error("pins lit during power-down");
   a_iso_forces_off: assert property (
      (isolate_control && !enhanced_mode) [*2] |->
      first_indicator_pin && second_indicator_pin)
      else $error("pins lit during isolate");
   a_enh_select: assert property (!legacy_indicator_select |->
      enhanced_mode && !indiv_mode)
      else $error("enhanced mode not selected");
   a_strap_kept: assert property (age_q == 3'h7 &&
      legacy_indicator_select && $past(legacy_indicator_select) |->
      $stable(indiv_mode))
      else $error("strap choice changed after capture");
   a_force_on_low: assert property (
      (enh_ok && cfg_first.func == 4'hf) [*2] |-> !first_indicator_pin)
      else $error("forced-on pin not low");
   a_force_off_high: assert property (
      (enhanced_mode && cfg_second.func == 4'he) [*2] |->
      second_indicator_pin)
      else $error("forced-off pin not high");
   a_rsvd_code_off: assert property ((enhanced_mode &&
      cfg_first.func inside {4'h7, 4'hb, 4'hd}) [*2] |->
      first_indicator_pin)
      else $error("reserved code lit the pin");
   a_anfault_shown: assert property (
      (enh_ok && cfg_second.func == 4'hc) [*2] |->
      second_indicator_pin == !$past(status.an_fault))
      else $error("fault pin wrong");
   a_tri_unlinked: assert property ((!enhanced_mode && !indiv_mode &&
      !status.link_up) [*2] |->
      first_indicator_pin && second_indicator_pin)
      else $error("tri-colour lit without link");
   a_indiv_link_on: assert property (
      (leg_ok && indiv_mode && status.link_up) [*2] |->
      !second_indicator_pin)
      else $error("link pin not low");
endmodule

// ---- tb/pled_led_model.sv ----
// Purpose: Two external indicators with series resistors
// Assumes: Anode to supply, cathode to the pin
// Notes:   A low pin lights its indicator
`timescale 1ns/100ps
module pled_led_model (
   input  wire logic first_indicator_pin,
   input  wire logic second_indicator_pin,
   output logic      lit_first,
   output logic      lit_second
);
   assign lit_first  = ~first_indicator_pin;
   assign lit_second = ~second_indicator_pin;
endmodule

// ---- tb/test_phy_led_status_driver.sv ----
// Purpose: Self-checking bench for the indicator driver
// Assumes: Inputs driven at the falling clock edge
// Notes:   No shortening parameters, so flash length is not timed
`timescale 1ns/100ps
module test_phy_led_status_driver;
   logic                    clk;
   logic                    resetn;
   logic                    style_strap;
   logic                    legacy_indicator_select;
   logic                    isolate_control;
   logic                    power_down;
   logic                    pulsing_en;
   logic                    act_tx_only;
   pled_pkg::pled_status_t  status;
   pled_pkg::pled_pin_cfg_t cfg_first;
   pled_pkg::pled_pin_cfg_t cfg_second;
   logic                    first_indicator_pin;
   logic                    second_indicator_pin;
   logic                    indiv_mode;
   logic                    enhanced_mode;
   logic                    lit_first;
   logic                    lit_second;
   int                      n_errors;
   int                      tests_run;
   int                      cycles;
   int                      lit_cnt;
   pled_pkg::pled_speed_t   spd [3] = '{pled_pkg::PLED_SPD_100,
                                        pled_pkg::PLED_SPD_10,
                                        pled_pkg::PLED_SPD_1000};
   logic                    fdx [3] = '{1'b1, 1'b0, 1'b1};
   logic                    anf [3] = '{1'b0, 1'b1, 1'b0};
   // Expected pin level per function code, bit index is the code
   logic [15:0]             expv [3] = '{16'h7eaa, 16'h6f96, 16'h7ecc};

   pled_top dut (.clk, .resetn, .style_strap, .legacy_indicator_select,
      .isolate_control, .power_down, .pulsing_en, .act_tx_only, .status,
      .cfg_first, .cfg_second, .first_indicator_pin, .second_indicator_pin,
      .indiv_mode, .enhanced_mode);

   pled_led_model leds (.first_indicator_pin, .second_indicator_pin,
      .lit_first, .lit_second);

   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic do_reset(input logic strap, input logic legacy);
      resetn = 1'b0;
      style_strap = strap;
      legacy_indicator_select = legacy;
      wait_cyc(6);
      resetn = 1'b1;
      wait_cyc(5);
   endtask

   // Registered pins: three edges covers the timer stage too
   task automatic pins(input string what, input logic f, input logic s);
      wait_cyc(3);
      chk({what, " first"}, first_indicator_pin, f);
      chk({what, " second"}, second_indicator_pin, s);
   endtask

   task automatic done(input string t);
      $display("test %s finished", t);
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         n_errors++;
         results();
      end
   end

   initial begin
      resetn = 1'b0;
      style_strap = 1'b1;
      legacy_indicator_select = 1'b1;
      isolate_control = 1'b0;
      power_down = 1'b0;
      pulsing_en = 1'b0;
      act_tx_only = 1'b0;
      status = '0;
      cfg_first = '0;
      cfg_second = '0;
      do_reset(1'b1, 1'b1);
      chk("individual", indiv_mode, 1'b1);
      style_strap = 1'b0;
      wait_cyc(4);
      chk("strap held", indiv_mode, 1'b1);
      status.link_up = 1'b1;
      status.speed = pled_pkg::PLED_SPD_1000;
      pins("indiv link", 1'b1, 1'b0);
      isolate_control = 1'b1;
      pins("indiv iso", 1'b1, 1'b1);
      isolate_control = 1'b0;
      power_down = 1'b1;
      pins("indiv pd", 1'b1, 1'b1);
      power_down = 1'b0;
      done("individual");
      status.link_up = 1'b0;
      do_reset(1'b0, 1'b1);
      chk("tri", {indiv_mode, enhanced_mode}, 2'b00);
      pins("tri no link", 1'b1, 1'b1);
      status.link_up = 1'b1;
      for (int i = 0; i < 3; i++) begin
         status.speed = pled_pkg::pled_speed_t'(i[1:0]);
         pins("tri speed", i == 2, i == 1);
      end
      status.rx_act = 1'b1;
      pins("tri act", 1'b1, 1'b1);
      status.rx_act = 1'b0;
      isolate_control = 1'b1;
      pins("tri iso", 1'b1, 1'b1);
      isolate_control = 1'b0;
      done("tri-colour");
      do_reset(1'b0, 1'b0);
      chk("enhanced", enhanced_mode, 1'b1);
      for (int p = 0; p < 3; p++) begin
         status.speed = spd[p];
         status.full_duplex = fdx[p];
         status.an_fault = anf[p];
         for (int c = 0; c < 16; c++) begin
            cfg_first.func = c[3:0];
            cfg_second.func = c[3:0];
            pins("func", expv[p][c], expv[p][c]);
         end
      end
      cfg_first.func = pled_pkg::FN_DUPLEX;
      cfg_second.func = pled_pkg::FN_COLL;
      status.full_duplex = 1'b0;
      pins("no coll", 1'b1, 1'b1);
      status.collision = 1'b1;
      pins("coll", 1'b0, 1'b0);
      status.collision = 1'b0;
      done("functions");
      do_reset(1'b1, 1'b0);
      cfg_first = '{pled_pkg::FN_ACT, 1'b0, 1'b0, 2'h3};
      cfg_second = '{pled_pkg::FN_ACT, 1'b1, 1'b1, 2'h0};
      act_tx_only = 1'b1;
      status.rx_act = 1'b1;
      pins("rx only", 1'b1, 1'b1);
      status.tx_act = 1'b1;
      pins("tx act", 1'b0, 1'b1);
      cfg_first.func = pled_pkg::FN_LINK_ANY;
      pins("link act", 1'b1, 1'b1);
      status.rx_act = 1'b0;
      status.tx_act = 1'b0;
      done("activity");
      do_reset(1'b1, 1'b0);
      cfg_first.func = pled_pkg::FN_ON;
      cfg_second.func = pled_pkg::FN_OFF;
      pulsing_en = 1'b1;
      wait_cyc(3);
      lit_cnt = 0;
      repeat (pled_pkg::PULSE_PERIOD) begin
         @(negedge clk);
         lit_cnt += int'(lit_first);
      end
      chk("pulse on", lit_cnt, pled_pkg::PULSE_ON);
      chk("pulse off", lit_second, 1'b0);
      power_down = 1'b1;
      pins("enh pd", 1'b1, 1'b1);
      done("pulsing");
      results();
   end
endmodule

bind pled_top pled_props u_props (.clk, .resetn, .style_strap,
   .legacy_indicator_select, .isolate_control, .power_down, .pulsing_en,
   .act_tx_only, .status, .cfg_first, .cfg_second, .first_indicator_pin,
   .second_indicator_pin, .indiv_mode, .enhanced_mode);
